// >>> design/fmap_pkg.sv
package fmap_pkg;

  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_COP = 6'h11;
  localparam logic [5:0] OPC_COPX = 6'h13;
  localparam logic [4:0] SUB_MOVE_TO = 5'h04;
  localparam logic [4:0] FMT_S = 5'h10;
  localparam logic [4:0] FMT_D = 5'h11;
  localparam logic [5:0] FN_MUL = 6'h02;
  localparam logic [5:0] FN_NEG = 6'h07;
  localparam logic [5:0] FN_INDEXED_PREFETCH = 6'h0F;
  localparam logic [2:0] XOP_NMADD = 3'h6;
  localparam logic [2:0] XOP_NMSUB = 3'h7;
  localparam logic [2:0] XFMT_S = 3'h0;
  localparam logic [2:0] XFMT_D = 3'h1;

  // ---------------------------------------------------------------
  // Prefetch hint values
  // ---------------------------------------------------------------
  localparam logic [4:0] HINT_LOAD = 5'h00;
  localparam logic [4:0] HINT_STORE = 5'h01;
  localparam logic [4:0] HINT_LOAD_STREAM = 5'h04;
  localparam logic [4:0] HINT_STORE_STREAM = 5'h05;
  localparam logic [4:0] HINT_LOAD_RETAIN = 5'h06;
  localparam logic [4:0] HINT_STORE_RETAIN = 5'h07;

  // Architecture level that writes moves at once
  localparam logic [2:0] LEVEL_EXT = 3'h4;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FCS = 8'h04;
  localparam logic [7:0] REG_GPRA_LO = 8'h08;
  localparam logic [7:0] REG_GPRA_HI = 8'h0C;
  localparam logic [7:0] REG_GPRB_LO = 8'h10;
  localparam logic [7:0] REG_GPRB_HI = 8'h14;
  localparam logic [7:0] REG_INSTR = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_EXC = 8'h20;
  localparam logic [7:0] REG_FSEL = 8'h24;
  localparam logic [7:0] REG_FVAL_LO = 8'h28;
  localparam logic [7:0] REG_FVAL_HI = 8'h2C;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_FPEN_BIT = 3;
  localparam int CTRL_EXTEN_BIT = 4;
  localparam int CTRL_FP64_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h3C;
  localparam logic [1:0] FCS_RM_RST = 2'h0;
  localparam int EXC_INEXACT = 0;
  localparam int EXC_UNDERFLOW = 1;
  localparam int EXC_OVERFLOW = 2;
  localparam int EXC_INVALID = 3;
  localparam int EXC_UNIMPL = 4;
  localparam int EXC_COP_UNUSABLE = 5;
  localparam int EXC_RESERVED = 6;
  localparam int EXC_W = 7;

  // Datapath operations and arithmetic model
  localparam logic [1:0] FOP_MUL = 2'h0;
  localparam logic [1:0] FOP_ADD = 2'h1;
  localparam logic [1:0] FOP_SUB = 2'h2;
  localparam logic ARITH_FUSED = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    OP_NONE = 7'h01,
    OP_MOVE = 7'h02,
    OP_MUL = 7'h04,
    OP_NEG = 7'h08,
    OP_NMADD = 7'h10,
    OP_NMSUB = 7'h20,
    OP_INDEXED_PREFETCH = 7'h40
  } fmap_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DEC = 4'h2,
    ST_FPU = 4'h4,
    ST_PF = 4'h8
  } fmap_state_e;

  typedef enum logic [2:0] {
    PF_IDLE = 3'h1,
    PF_XLAT = 3'h2,
    PF_REQ = 3'h4
  } fmap_pf_e;

endpackage : fmap_pkg

// >>> design/fmap_dec_if.sv
`timescale 1ns/10ps
interface fmap_dec_if
  import fmap_pkg::*;
();
  fmap_op_e op;       // Decoded operation
  logic [4:0] fa;     // First FP source
  logic [4:0] fb;     // Second FP source
  logic [4:0] fc;     // FP addend
  logic [4:0] fdst;   // FP destination
  logic dbl;          // Double format
  logic [4:0] hint;   // Prefetch hint
  logic cop_unusable; // Coprocessor disabled
  logic reserved;     // Not a known instruction

  modport dec (output op, fa, fb, fc, fdst, dbl, hint, cop_unusable,
    reserved);
  modport core (input op, fa, fb, fc, fdst, dbl, hint, cop_unusable,
    reserved);
endinterface : fmap_dec_if

// >>> design/fmap_decode.sv
`timescale 1ns/10ps
module fmap_decode
  import fmap_pkg::*;
(
  // Instruction and enables
  input wire logic [31:0] instr_i,
  input wire logic [2:0] level_i,
  input wire logic fp_en_i,
  input wire logic ext_en_i,
  // Decoded fields
  fmap_dec_if.dec dec
);

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire [5:0] opc = instr_i[31:26];
  wire [4:0] fmt = instr_i[25:21];
  wire [5:0] fn = instr_i[5:0];
  wire [2:0] xop = instr_i[5:3];
  wire [2:0] xfmt = instr_i[2:0];
  wire is_cop = opc == OPC_COP;
  wire is_copx = opc == OPC_COPX;
  wire fmt_ok = (fmt == FMT_S) || (fmt == FMT_D);
  wire xfmt_ok = (xfmt == XFMT_S) || (xfmt == XFMT_D);
  // Extended group only at level LEVEL_EXT or above with it enabled
  wire x_ok = is_copx & (level_i >= LEVEL_EXT) & ext_en_i;

  // ---------------------------------------------------------------
  // Operation match
  // ---------------------------------------------------------------
  wire m_move = is_cop & (fmt == SUB_MOVE_TO)
    & (instr_i[10:0] == 11'h000);
  wire m_mul = is_cop & fmt_ok & (fn == FN_MUL);
  wire m_neg = is_cop & fmt_ok & (instr_i[20:16] == 5'h00)
    & (fn == FN_NEG);
  wire m_nmadd = x_ok & xfmt_ok & (xop == XOP_NMADD);
  wire m_nmsub = x_ok & xfmt_ok & (xop == XOP_NMSUB);
  wire m_indexed_prefetch = x_ok & (fn == FN_INDEXED_PREFETCH)
    & (instr_i[10:6] == 5'h00);
  wire any = m_move | m_mul | m_neg | m_nmadd | m_nmsub | m_indexed_prefetch;
  wire unusable = (is_cop | is_copx) & ~fp_en_i;

  // Operation select, disabled coprocessor wins
  assign dec.op = unusable ? OP_NONE :
    m_move ? OP_MOVE : m_mul ? OP_MUL : m_neg ? OP_NEG :
    m_nmadd ? OP_NMADD : m_nmsub ? OP_NMSUB :
    m_indexed_prefetch ? OP_INDEXED_PREFETCH : OP_NONE;
  assign dec.cop_unusable = unusable;
  assign dec.reserved = ~unusable & ~any;
  assign dec.fa = instr_i[15:11];
  assign dec.fb = instr_i[20:16];
  assign dec.fc = instr_i[25:21];
  assign dec.fdst = m_move ? instr_i[15:11] : instr_i[10:6];
  assign dec.dbl = is_cop ? (fmt == FMT_D) : (xfmt == XFMT_D);
  assign dec.hint = instr_i[15:11];

endmodule : fmap_decode

// >>> design/fmap_prefetch.sv
`timescale 1ns/10ps
module fmap_prefetch
  import fmap_pkg::*;
#(
  parameter int ADDR_W = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command
  input wire logic start_i,
  input wire logic [ADDR_W-1:0] base_i,
  input wire logic [ADDR_W-1:0] index_i,
  input wire logic [4:0] hint_i,
  // Translation and cache
  input wire logic uncached_i,
  input wire logic fault_i,
  input wire logic ack_i,
  output logic req_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic store_o,
  output logic stream_o,
  output logic retain_o,
  // Outcome
  output logic done_o,
  output logic issued_o,
  output logic dropped_o
);

  // Region bits need at least two address bits
  if (ADDR_W < 2) begin : g_bad_width
    $error("fmap_prefetch: ADDR_W too small");
  end

  // ---------------------------------------------------------------
  // Hint classes, undefined values act as plain load
  // ---------------------------------------------------------------
  wire h_store = (hint_i == HINT_STORE) || (hint_i == HINT_STORE_STREAM)
    || (hint_i == HINT_STORE_RETAIN);
  wire h_stream = (hint_i == HINT_LOAD_STREAM)
    || (hint_i == HINT_STORE_STREAM);
  wire h_retain = (hint_i == HINT_LOAD_RETAIN)
    || (hint_i == HINT_STORE_RETAIN);
  wire [ADDR_W-1:0] next_addr = base_i + index_i;
  // Faults are swallowed, uncached space never touched
  wire skip = fault_i | uncached_i;
  fmap_pf_e state;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= PF_IDLE;
      req_o <= 1'b0;
      addr_o <= '0;
      {store_o, stream_o, retain_o} <= 3'h0;
      {done_o, issued_o, dropped_o} <= 3'h0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        PF_IDLE:
        begin
          // Latch address and hint class
          if (start_i)
          begin
            addr_o <= next_addr;
            {store_o, stream_o, retain_o} <= {h_store, h_stream, h_retain};
            state <= PF_XLAT;
          end
        end
        PF_XLAT:
        begin
          // Drop quietly or ask the cache for the block
          if (skip)
          begin
            {issued_o, dropped_o} <= 2'h1;
            done_o <= 1'b1;
            state <= PF_IDLE;
          end
          else
          begin
            req_o <= 1'b1;
            state <= PF_REQ;
          end
        end
        PF_REQ:
        begin
          // Wait for the cache to take it
          if (ack_i)
          begin
            req_o <= 1'b0;
            {issued_o, dropped_o} <= 2'h2;
            done_o <= 1'b1;
            state <= PF_IDLE;
          end
        end
        default: state <= PF_IDLE;
      endcase
    end
  end

endmodule : fmap_prefetch

// >>> design/fmap_core.sv
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
// Function
// - Decode word move by opcode and subop
// - Move writes low word, upper half undefined
// - Older levels delay move by one instruction
// - Multiply exactly, round once by mode
// - Negate only flips sign bit
// - Negate of NaN signals invalid operation
// - Negative multiply-add rounds then inverts sign
// - Negative multiply-subtract rounds then inverts sign
// - One fixed arithmetic model for fused ops
// - Non-format operands give undefined result
// - Prefetch address is base plus index
// - Prefetch never changes architectural state
// - Prefetch raises no addressing exceptions
// - Ignored fault means no data fetched
// - Never prefetch uncached locations
// - Prefetch uses the address access type
// - Cached location fetches enclosing block
// - Hint table: load, store, streamed, retained
// - Undefined hint does plain load prefetch
module fmap_core
  import fmap_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Arithmetic datapath
  output logic fpu_req_o,
  output logic [1:0] fpu_op_o,
  output logic fpu_dbl_o,
  output logic [1:0] fpu_rm_o,
  output logic fpu_fused_o,
  output logic [63:0] fpu_a_o,
  output logic [63:0] fpu_b_o,
  output logic [63:0] fpu_c_o,
  input wire logic fpu_done_i,
  input wire logic [63:0] fpu_res_i,
  input wire logic [4:0] fpu_flags_i,
  // Prefetch path to translation and cache
  output logic pf_req_o,
  output logic [63:0] pf_addr_o,
  output logic pf_store_o,
  output logic pf_stream_o,
  output logic pf_retain_o,
  input wire logic pf_uncached_i,
  input wire logic pf_fault_i,
  input wire logic pf_ack_i
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction : merge

  // Sign inversion in the chosen format
  function automatic logic [63:0] flip_sign(input logic [63:0] v,
    input logic dbl);
    flip_sign = v;
    if (dbl)
      flip_sign[63] = ~v[63];
    else
      flip_sign[31] = ~v[31];
  endfunction : flip_sign

  // NaN test in the chosen format
  function automatic logic is_nan(input logic [63:0] v, input logic dbl);
    if (dbl)
      is_nan = (&v[62:52]) & (|v[51:0]);
    else
      is_nan = (&v[30:23]) & (|v[22:0]);
  endfunction : is_nan

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [5:0] ctrl;          // Level and enables
  logic [1:0] rm;            // Rounding mode
  logic [63:0] gpr_a;        // Move source or prefetch base
  logic [63:0] gpr_b;        // Prefetch index
  logic [31:0] instr;        // Last issued instruction
  logic [EXC_W-1:0] exc;     // Sticky exception conditions
  logic [4:0] fsel;          // Register read window select
  logic [63:0] fp_register [32];     // FP register file
  logic pend_v;              // Delayed move waiting
  logic [4:0] pend_idx;      // Delayed move target
  logic [31:0] pend_data;    // Delayed move word
  logic [4:0] fd_q;          // Datapath result target
  logic neg_q;               // Invert datapath result sign
  logic ack;                 // Bus acknowledge
  logic [31:0] rd_q;         // Bus read data
  fmap_state_e state;        // Sequencer state

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [2:0] level = ctrl[CTRL_LEVEL_LSB +: 3];
  wire fp_en = ctrl[CTRL_FPEN_BIT];
  wire ext_en = ctrl[CTRL_EXTEN_BIT];
  wire fp64 = ctrl[CTRL_FP64_BIT];
  fmap_dec_if dif ();
  fmap_decode u_dec (
    .instr_i(instr),
    .level_i(level),
    .fp_en_i(fp_en),
    .ext_en_i(ext_en),
    .dec(dif.dec)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire busy = state != ST_IDLE;
  wire wb_hit = wb_cyc_i & wb_stb_i & ~ack;
  wire adr_instr = wb_adr_i == REG_INSTR;
  // Hold off a new instruction while one runs
  wire wb_take = wb_hit & ~(wb_we_i & adr_instr & busy);
  wire wr = wb_take & wb_we_i;
  wire issue = wr & adr_instr;
  wire [31:0] w_ctrl = merge({26'h0, ctrl}, wb_dat_i, wb_sel_i);
  wire [31:0] w_fcs = merge({30'h0, rm}, wb_dat_i, wb_sel_i);
  wire [31:0] w_fsel = merge({27'h0, fsel}, wb_dat_i, wb_sel_i);
  wire [63:0] fwin = fp_register[fsel];
  wire pf_done;    // Prefetch finished
  wire pf_issued;  // Last prefetch reached the cache
  wire pf_dropped; // Last prefetch dropped quietly
  wire [31:0] status = {28'h0, pend_v, pf_dropped, pf_issued, busy};
  // Read mux, unmapped reads as zero
  wire [31:0] rd_word =
    (wb_adr_i == REG_CTRL) ? {26'h0, ctrl} :
    (wb_adr_i == REG_FCS) ? {30'h0, rm} :
    (wb_adr_i == REG_GPRA_LO) ? gpr_a[31:0] :
    (wb_adr_i == REG_GPRA_HI) ? gpr_a[63:32] :
    (wb_adr_i == REG_GPRB_LO) ? gpr_b[31:0] :
    (wb_adr_i == REG_GPRB_HI) ? gpr_b[63:32] :
    adr_instr ? instr :
    (wb_adr_i == REG_STATUS) ? status :
    (wb_adr_i == REG_EXC) ? {25'h0, exc} :
    (wb_adr_i == REG_FSEL) ? {27'h0, fsel} :
    (wb_adr_i == REG_FVAL_LO) ? fwin[31:0] :
    (wb_adr_i == REG_FVAL_HI) ? (fp64 ? fwin[63:32] : 32'h0) :
    32'h0;

  // ---------------------------------------------------------------
  // Execution decode
  // ---------------------------------------------------------------
  wire dec_now = state == ST_DEC;
  wire do_move = dec_now & (dif.op == OP_MOVE);
  wire do_neg = dec_now & (dif.op == OP_NEG);
  wire do_fpu = dec_now & ((dif.op == OP_MUL) | (dif.op == OP_NMADD)
    | (dif.op == OP_NMSUB));
  wire do_pf = dec_now & (dif.op == OP_INDEXED_PREFETCH);
  wire fpu_fin = (state == ST_FPU) & fpu_done_i;
  wire move_now = level >= LEVEL_EXT;
  // Register numbers and formats used as given
  wire [63:0] src_a = fp_register[dif.fa];
  wire [63:0] src_b = fp_register[dif.fb];
  wire [63:0] src_c = fp_register[dif.fc];
  wire [63:0] move_val = {32'h0, gpr_a[31:0]};
  wire [63:0] neg_val = flip_sign(src_a, dif.dbl);
  wire [63:0] fpu_val = neg_q ? flip_sign(fpu_res_i, fpu_dbl_o)
    : fpu_res_i;
  wire [1:0] next_fop = (dif.op == OP_NMADD) ? FOP_ADD :
    (dif.op == OP_NMSUB) ? FOP_SUB : FOP_MUL;

  // ---------------------------------------------------------------
  // Exception conditions, set wins over clear
  // ---------------------------------------------------------------
  wire [EXC_W-1:0] exc_set;
  wire [EXC_W-1:0] exc_clr = (wr & (wb_adr_i == REG_EXC) & wb_sel_i[0])
    ? wb_dat_i[EXC_W-1:0] : '0;
  assign exc_set[EXC_INEXACT] = fpu_fin & fpu_flags_i[EXC_INEXACT];
  assign exc_set[EXC_UNDERFLOW] = fpu_fin & fpu_flags_i[EXC_UNDERFLOW];
  assign exc_set[EXC_OVERFLOW] = fpu_fin & fpu_flags_i[EXC_OVERFLOW];
  assign exc_set[EXC_INVALID] = (fpu_fin & fpu_flags_i[EXC_INVALID])
    | (do_neg & is_nan(src_a, dif.dbl));
  assign exc_set[EXC_UNIMPL] = fpu_fin & fpu_flags_i[EXC_UNIMPL];
  assign exc_set[EXC_COP_UNUSABLE] = dec_now & dif.cop_unusable;
  assign exc_set[EXC_RESERVED] = dec_now & dif.reserved;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      exc <= '0;
    else
      exc <= (exc & ~exc_clr) | exc_set;
  end

  // ---------------------------------------------------------------
  // Bus handshake and read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rd_q <= 32'h0;
    end
    else
    begin
      ack <= wb_take;
      if (wb_take & ~wb_we_i)
        rd_q <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= CTRL_RST;
      rm <= FCS_RM_RST;
      {gpr_a, gpr_b} <= '0;
      instr <= 32'h0;
      fsel <= 5'h00;
    end
    else if (wr)
    begin
      // Byte lanes honoured per register
      case (wb_adr_i)
        REG_CTRL: ctrl <= w_ctrl[5:0];
        REG_FCS: rm <= w_fcs[1:0];
        REG_GPRA_LO: gpr_a[31:0] <= merge(gpr_a[31:0], wb_dat_i, wb_sel_i);
        REG_GPRA_HI: gpr_a[63:32] <= merge(gpr_a[63:32], wb_dat_i, wb_sel_i);
        REG_GPRB_LO: gpr_b[31:0] <= merge(gpr_b[31:0], wb_dat_i, wb_sel_i);
        REG_GPRB_HI: gpr_b[63:32] <= merge(gpr_b[63:32], wb_dat_i, wb_sel_i);
        REG_INSTR: instr <= merge(instr, wb_dat_i, wb_sel_i);
        REG_FSEL: fsel <= w_fsel[4:0];
        default: fsel <= fsel;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE: state <= issue ? ST_DEC : ST_IDLE;
        ST_DEC: state <= do_fpu ? ST_FPU : do_pf ? ST_PF : ST_IDLE;
        ST_FPU: state <= fpu_done_i ? ST_IDLE : ST_FPU;
        ST_PF: state <= pf_done ? ST_IDLE : ST_PF;
        default: state <= ST_IDLE;
      endcase
  end

  // ---------------------------------------------------------------
  // Delayed move for older levels
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_v <= 1'b0;
      pend_idx <= 5'h00;
      pend_data <= 32'h0;
    end
    else if (dec_now)
    begin
      // Lands after the next instruction has read its sources
      pend_v <= do_move & ~move_now;
      pend_idx <= dif.fdst;
      pend_data <= gpr_a[31:0];
    end
  end

  // ---------------------------------------------------------------
  // FP register file writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      for (int i = 0; i < 32; i++)
        fp_register[i] <= 64'h0;
    else
    begin
      if (dec_now & pend_v)
        fp_register[pend_idx] <= {32'h0, pend_data};
      if (do_move & move_now)
        fp_register[dif.fdst] <= move_val;
      if (do_neg)
        fp_register[dif.fdst] <= neg_val;
      if (fpu_fin)
        fp_register[fd_q] <= fpu_val;
    end
  end

  // ---------------------------------------------------------------
  // Datapath request, held until done
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fpu_req_o <= 1'b0;
      fpu_op_o <= FOP_MUL;
      {fpu_dbl_o, neg_q, fd_q} <= '0;
      {fpu_a_o, fpu_b_o, fpu_c_o} <= '0;
      fpu_rm_o <= FCS_RM_RST;
    end
    else if (do_fpu)
    begin
      fpu_req_o <= 1'b1;
      fpu_op_o <= next_fop;
      fpu_rm_o <= rm;
      fpu_dbl_o <= dif.dbl;
      neg_q <= dif.op != OP_MUL;
      fd_q <= dif.fdst;
      {fpu_a_o, fpu_b_o, fpu_c_o} <= {src_a, src_b, src_c};
    end
    else if (fpu_done_i)
      fpu_req_o <= 1'b0;
  end

  // Single fused model for every negative fused op
  assign fpu_fused_o = ARITH_FUSED;

  // ---------------------------------------------------------------
  // Prefetch, touches no register or exception state
  // ---------------------------------------------------------------
  fmap_prefetch #(
    .ADDR_W(64)
  ) u_pf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(do_pf),
    .base_i(gpr_a),
    .index_i(gpr_b),
    .hint_i(dif.hint),
    .uncached_i(pf_uncached_i),
    .fault_i(pf_fault_i),
    .ack_i(pf_ack_i),
    .req_o(pf_req_o),
    .addr_o(pf_addr_o),
    .store_o(pf_store_o),
    .stream_o(pf_stream_o),
    .retain_o(pf_retain_o),
    .done_o(pf_done),
    .issued_o(pf_issued),
    .dropped_o(pf_dropped)
  );

  // Bus outputs
  assign wb_ack_o = ack;
  assign wb_dat_o = rd_q;

endmodule : fmap_core

// >>> testbench/fmap_core_assertions.sv
`timescale 1ns/10ps
module fmap_core_assertions (
  // Watched ports
  input wire logic clk_i, rst_i, wb_ack_o, fpu_req_o, fpu_done_i,
  input wire logic fpu_fused_o, pf_req_o, pf_ack_i, pf_uncached_i,
  input wire logic pf_fault_i, pf_stream_o, pf_retain_o,
  input wire logic [63:0] fpu_a_o, pf_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fused_model: assert property (fpu_fused_o)
    else $error("model");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  a_fpu_hold: assert property (fpu_req_o && !fpu_done_i |=>
    fpu_req_o && $stable(fpu_a_o)) else $error("fpu hold");
  a_fpu_drop: assert property (fpu_done_i |=> !fpu_req_o)
    else $error("fpu drop");
  a_pf_hold: assert property (pf_req_o && !pf_ack_i |=>
    pf_req_o && $stable(pf_addr_o)) else $error("pf hold");
  a_pf_drop: assert property (pf_ack_i |=> !pf_req_o) else $error("pf");
  a_no_uncached: assert property (pf_req_o |-> !pf_uncached_i)
    else $error("uncached");
  a_no_fault: assert property (pf_req_o |-> !pf_fault_i)
    else $error("fault");
  a_hint_class: assert property (!(pf_stream_o && pf_retain_o))
    else $error("class");
  // Main scenarios
  c_fpu: cover property (fpu_done_i);
  c_pf: cover property (pf_req_o && pf_ack_i);
  c_bus: cover property (wb_ack_o);
endmodule : fmap_core_assertions
bind fmap_core fmap_core_assertions i_fmap_core_assertions (.*);

// >>> testbench/fmap_partner.sv
`timescale 1ns/10ps
module fmap_partner (
  // Control
  input wire logic clk_i, rst_i,
  input wire logic [3:0] lat_i,
  // Datapath side
  input wire logic fpu_req_o,
  input wire logic [1:0] fpu_op_o,
  input wire logic [63:0] fpu_a_o, fpu_b_o, fpu_c_o,
  output logic fpu_done_i,
  output logic [63:0] fpu_res_i,
  output logic [4:0] fpu_flags_i,
  // Cache side
  input wire logic pf_req_o,
  input wire logic [63:0] pf_addr_o,
  output logic pf_uncached_i, pf_fault_i, pf_ack_i
);
  logic [3:0] cnt; // Cycles into request
  logic [63:0] prod; // Integer stand-in product
  assign prod = fpu_a_o * fpu_b_o;
  assign fpu_done_i = fpu_req_o && cnt == lat_i;
  assign pf_ack_i = pf_req_o && cnt == lat_i;
  assign fpu_res_i = fpu_op_o == 2'h1 ? prod + fpu_c_o :
    fpu_op_o == 2'h2 ? prod - fpu_c_o : prod;
  assign fpu_flags_i = fpu_op_o == 2'h2 ? 5'h08 : 5'h01;
  // Translation attributes by address bit
  assign pf_uncached_i = pf_addr_o[40];
  assign pf_fault_i = pf_addr_o[41];
  // Answer delay counter
  always_ff @(posedge clk_i)
    cnt <= (rst_i || !(fpu_req_o || pf_req_o) || fpu_done_i || pf_ack_i)
      ? 4'h0 : cnt + 4'h1;
endmodule : fmap_partner

// >>> testbench/fmap_core_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %0t %h", $time, a); end end
module fmap_core_bench
  import fmap_pkg::*;
;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, wb_ack_o, fpu_req_o, fpu_dbl_o, fpu_fused_o;
  logic fpu_done_i, pf_req_o, pf_store_o, pf_stream_o, pf_retain_o;
  logic pf_uncached_i, pf_fault_i, pf_ack_i;
  logic [1:0] fpu_op_o, fpu_rm_o;
  logic [3:0] wb_sel_i = 4'hF, lat_i = 4'h0;
  logic [4:0] fpu_flags_i;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat, lo;
  logic [63:0] fpu_a_o, fpu_b_o, fpu_c_o, fpu_res_i, pf_addr_o;
  logic [66:0] cap; // Last accepted prefetch
  int err_count = 0, checks = 0, tmo = 0;
  fmap_core i_fmap_core (.*);
  fmap_partner i_fmap_partner (.*);
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (pf_req_o && pf_ack_i)
      cap <= {pf_addr_o, pf_store_o, pf_stream_o, pf_retain_o};
    if (fpu_req_o)
      `CHK({fpu_rm_o, fpu_dbl_o}, 3'h5)
    if (++tmo == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // One classic bus cycle
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : bus
  // Issue and wait for idle
  task automatic run(input logic [31:0] ins);
    bus(1'h1, REG_INSTR, ins);
    do bus(1'h0, REG_STATUS, 32'h0); while (rdat[0]);
  endtask : run
  task automatic fv(input logic [4:0] r, input logic [63:0] e);
    bus(1'h1, REG_FSEL, {27'h0, r});
    bus(1'h0, REG_FVAL_LO, 32'h0);
    lo = rdat;
    bus(1'h0, REG_FVAL_HI, 32'h0);
    `CHK({rdat, lo}, e)
  endtask : fv
  task automatic mv(input logic [4:0] r, input logic [31:0] v);
    bus(1'h1, REG_GPRA_LO, v);
    run({OPC_COP, SUB_MOVE_TO, 5'h0, r, 11'h0});
  endtask : mv
  task automatic ar(input logic [31:0] ins, input logic [4:0] d,
    input logic [63:0] e, input logic [31:0] x);
    run(ins);
    fv(d, e);
    bus(1'h0, REG_EXC, 32'h0);
    `CHK(rdat, x)
    bus(1'h1, REG_EXC, 32'h7F);
  endtask : ar
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    bus(1'h0, REG_CTRL, 32'h0);
    `CHK(rdat, 32'h3C)
    bus(1'h1, 8'hF0, 32'h5);
    bus(1'h0, 8'hF0, 32'h0);
    `CHK(rdat, 32'h0)
    mv(5'h1, 32'h10000);
    mv(5'h2, 32'h30000);
    fv(5'h1, 64'h10000);
    bus(1'h1, REG_CTRL, 32'h3B);
    mv(5'h4, 32'h3F800000);
    `CHK(rdat, 32'h8)
    fv(5'h4, 64'h0);
    run({OPC_COP, FMT_S, 5'h0, 5'h4, 5'h5, FN_NEG});
    fv(5'h5, 64'h80000000);
    fv(5'h4, 64'h3F800000);
    bus(1'h1, REG_CTRL, 32'h3C);
    bus(1'h1, REG_FCS, 32'h2);
    ar({OPC_COP, FMT_D, 5'h2, 5'h1, 5'h6, FN_MUL}, 5'h6,
      64'h300000000, 32'h1);
    lat_i <= 4'h5;
    ar({OPC_COPX, 5'h1, 5'h2, 5'h1, 5'h7, XOP_NMADD, XFMT_D}, 5'h7,
      64'h8000000300010000, 32'h1);
    ar({OPC_COPX, 5'h1, 5'h2, 5'h1, 5'h8, XOP_NMSUB, XFMT_D}, 5'h8,
      64'h80000002FFFF0000, 32'h8);
    mv(5'h3, 32'h7FC00000);
    ar({OPC_COP, FMT_S, 5'h0, 5'h3, 5'h9, FN_NEG}, 5'h9,
      64'hFFC00000, 32'h8);
    bus(1'h1, REG_GPRA_LO, 32'h1000);
    bus(1'h1, REG_GPRB_LO, 32'h234);
    for (int h = 0; h < 9; h++)
    begin
      run({OPC_COPX, 5'h1, 5'h2, 5'(h), 5'h0, FN_INDEXED_PREFETCH});
      `CHK(rdat, 32'h2)
      `CHK(cap, {64'h1234, h[0] && h != 3, h / 2 == 2, h / 2 == 3})
    end
    for (int k = 1; k < 3; k++)
    begin
      bus(1'h1, REG_GPRA_HI, 32'(k << 8));
      run({OPC_COPX, 5'h1, 5'h2, 5'h0, 5'h0, FN_INDEXED_PREFETCH});
      `CHK(rdat, 32'h4)
      bus(1'h0, REG_EXC, 32'h0);
      `CHK(rdat, 32'h0)
    end
    bus(1'h1, REG_CTRL, 32'h34);
    run({OPC_COP, SUB_MOVE_TO, 5'h0, 5'h9, 11'h0});
    run(32'hFFFFFFFF);
    bus(1'h0, REG_EXC, 32'h0);
    `CHK(rdat, 32'h60)
    conclude();
  end
endmodule : fmap_core_bench
